/* File: logic/gpwd_pkg.sv */
// constants, register map and carrier types for the gpio/watchdog config block
package gpwd_pkg;

	// ==========================================================
	// register indexes (byte address = index * 4)
	localparam logic [7:0] IDX_ACTIVATE = 8'h30; // function_activate
	localparam logic [7:0] IDX_BASE_HI = 8'h60; // io_base_high
	localparam logic [7:0] IDX_BASE_LO = 8'h61; // io_base_low
	localparam logic [7:0] IDX_A_DIR = 8'hE0; // port_a_direction
	localparam logic [7:0] IDX_A_VAL = 8'hE1; // port_a_value
	localparam logic [7:0] IDX_A_INV = 8'hE2; // port_a_invert
	localparam logic [7:0] IDX_A_STAT = 8'hE3; // port_a_edge_status
	localparam logic [7:0] IDX_B_DIR = 8'hE4; // port_b_direction
	localparam logic [7:0] IDX_B_VAL = 8'hE5; // port_b_value
	localparam logic [7:0] IDX_B_INV = 8'hE6; // port_b_invert
	localparam logic [7:0] IDX_B_STAT = 8'hE7; // port_b_edge_status
	localparam logic [7:0] IDX_WD_MODE = 8'hF5; // watchdog_mode_ctrl
	localparam logic [7:0] IDX_WD_COUNT = 8'hF6; // watchdog count / reload
	localparam logic [7:0] IDX_WD_STAT = 8'hF7; // watchdog time-out status
	localparam logic [7:0] IDX_IRQ_STAT = 8'hF8; // sticky event status
	localparam logic [7:0] IDX_IRQ_MASK = 8'hF9; // event mask

	// ==========================================================
	// reset values
	localparam logic [7:0] RST_ACTIVATE = 8'h02;
	localparam logic [7:0] RST_BASE = 8'h00;
	localparam logic [7:0] RST_DIR = 8'hFF;
	localparam logic [7:0] RST_A_VAL = 8'h00;
	localparam logic [7:0] RST_B_VAL = 8'h1F;
	localparam logic [7:0] RST_INV = 8'h00;
	localparam logic [7:0] RST_ZERO = 8'h00;

	// ==========================================================
	// field positions and writable masks
	localparam int ACT_WD_BIT = 0; // watchdog output and power led
	localparam int ACT_A_BIT = 1; // port a active
	localparam int ACT_B_BIT = 2; // port b active
	localparam logic [7:0] ACT_MASK = 8'h07;
	localparam int MODE_KEYBOARD_RESET_PIN_BIT = 1; // pulse keyboard reset on time-out
	localparam int MODE_KBC_BIT = 2; // controller reset edge raises time-out
	localparam int MODE_MIN_BIT = 3; // 0 seconds, 1 minutes
	localparam int MODE_FAST_BIT = 4; // unit divided by 1000
	localparam logic [7:0] MODE_MASK = 8'h1E;
	localparam int WDSTAT_BIT = 4; // time-out flag
	localparam logic [7:0] BASE_HI_MASK = 8'h0F;
	localparam logic [7:0] BASE_LO_MASK = 8'hFC; // 4-byte alignment
	localparam logic [11:0] BASE_MIN = 12'h100;
	localparam logic [11:0] BASE_MAX = 12'hFF8;
	localparam int IRQ_A_BIT = 0;
	localparam int IRQ_B_BIT = 1;
	localparam int IRQ_WD_BIT = 2;
	localparam logic [2:0] IRQ_MASK_BITS = 3'h7;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int MS_NS = 1000000; // one millisecond
	localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
	localparam int MS_PER_S = 1000;
	localparam int S_PER_MIN = 60;
	localparam int KEYBOARD_RESET_PIN_PULSE_NS = 1000; // least low time of reset pulse
	localparam int KEYBOARD_RESET_PIN_PULSE_CYCLES = (KEYBOARD_RESET_PIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [31:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} gpwd_wb_req_t;

	typedef struct packed {
		logic fast;
		logic minute;
		logic kbc_trig;
		logic keyboard_reset_pin_en;
	} gpwd_wdmode_t;

endpackage

/* File: logic/gpwd_top.sv */
// gpio ports, io base and watchdog mode configuration block, wishbone slave
`timescale 1ns/10ps
module gpwd_top
	import gpwd_pkg::*;
#(
	parameter int MS_TICK_CYCLES = MS_CYCLES // cycles per millisecond, shorten in simulation
) (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// wishbone slave
	input wire gpwd_wb_req_t wb_req_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// port a pins
	input wire logic [7:0] port_a_pins_i,
	output logic [7:0] port_a_pins_o,
	output logic [7:0] port_a_pins_oe_o,
	// port b pins
	input wire logic [7:0] port_b_pins_i,
	output logic [7:0] port_b_pins_o,
	output logic [7:0] port_b_pins_oe_o,
	// watchdog and keyboard signals
	input wire logic kbd_ctrl_reset_line_i,
	output logic watchdog_timeout_out_n_o,
	output logic keyboard_reset_pin_n_o,
	output logic power_led_o,
	// io base and interrupt
	output logic [11:0] io_base_o,
	output logic io_base_valid_o,
	output logic irq_o
);

	// ==========================================================
	// local sizes
	localparam int MSW = $clog2(MS_TICK_CYCLES + 1);
	localparam logic [MSW-1:0] MS_LAST = MSW'(MS_TICK_CYCLES - 1);
	localparam logic [9:0] SUB_LAST = 10'(MS_PER_S - 1);
	localparam logic [5:0] MIN_LAST = 6'(S_PER_MIN - 1);
	localparam logic [7:0] KB_LOAD = 8'(KEYBOARD_RESET_PIN_PULSE_CYCLES);

	// port read: inputs show pin through inversion, outputs show stored value
	function automatic logic [7:0] port_read(input logic [7:0] dir, input logic [7:0] val,
		input logic [7:0] inv, input logic [7:0] pin);
		port_read = (dir & (pin ^ inv)) | (~dir & val);
	endfunction

	// ==========================================================
	// state
	logic ack_reg, ack_next; // bus answer
	logic [7:0] rdat_reg, rdat_next; // captured read byte
	logic [7:0] act_reg, act_next; // activation
	logic [7:0] base_hi_reg, base_hi_next;
	logic [7:0] base_lo_reg, base_lo_next;
	logic [7:0] dir_reg [2], dir_next [2]; // index 0 port a, 1 port b
	logic [7:0] val_reg [2], val_next [2];
	logic [7:0] inv_reg [2], inv_next [2];
	logic [7:0] stat_reg [2], stat_next [2];
	logic [7:0] sync1_reg [2], sync1_next [2]; // first synchroniser stage
	logic [7:0] sync2_reg [2], sync2_next [2];
	logic [7:0] prev_reg [2], prev_next [2]; // previous synchronised sample
	gpwd_wdmode_t mode_reg, mode_next;
	logic [7:0] wdcnt_reg, wdcnt_next; // live counter
	logic wdstat_reg, wdstat_next;
	logic [MSW-1:0] ms_reg, ms_next; // cycles within a millisecond
	logic [9:0] sub_reg, sub_next; // milliseconds within a second
	logic [5:0] min_reg, min_next; // base units within a minute
	logic [7:0] kb_reg, kb_next; // keyboard reset pulse remaining
	logic kbc1_reg, kbc1_next, kbc2_reg, kbc2_next, kbc3_reg, kbc3_next;
	logic [2:0] irq_stat_reg, irq_stat_next;
	logic [2:0] irq_mask_reg, irq_mask_next;

	// ==========================================================
	// decode and events
	logic acc, wr_hit, rd_hit, mapped;
	logic [7:0] idx, wdat, rd_byte;
	logic [7:0] edge_v [2];
	logic [7:0] pin_v [2];
	logic ms_tick, sec_tick, base_tick, unit_tick, kbc_rise, timeout_evt, cnt_load;

	assign pin_v[0] = port_a_pins_i;
	assign pin_v[1] = port_b_pins_i;
	assign idx = wb_req_i.adr[9:2];
	assign wdat = wb_req_i.dat[7:0];
	assign acc = wb_req_i.cyc & wb_req_i.stb;
	// writes land on the edge where the master sees ack
	assign wr_hit = acc & ack_reg & wb_req_i.we & wb_req_i.sel[0];
	assign rd_hit = acc & ack_reg & ~wb_req_i.we;

	// read mux; unmapped indexes read zero, reserved bits zero
	always_comb begin
		rd_byte = 8'h00;
		mapped = (wb_req_i.adr[31:10] == 22'h0);
		case (idx)
			IDX_ACTIVATE: rd_byte = act_reg & ACT_MASK;
			IDX_BASE_HI: rd_byte = base_hi_reg;
			IDX_BASE_LO: rd_byte = base_lo_reg;
			IDX_A_DIR: rd_byte = dir_reg[0];
			IDX_A_VAL: rd_byte = port_read(dir_reg[0], val_reg[0], inv_reg[0], sync2_reg[0]);
			IDX_A_INV: rd_byte = inv_reg[0];
			IDX_A_STAT: rd_byte = stat_reg[0];
			IDX_B_DIR: rd_byte = dir_reg[1];
			IDX_B_VAL: rd_byte = port_read(dir_reg[1], val_reg[1], inv_reg[1], sync2_reg[1]);
			IDX_B_INV: rd_byte = inv_reg[1];
			IDX_B_STAT: rd_byte = stat_reg[1];
			IDX_WD_MODE: rd_byte = {3'h0, mode_reg, 1'b0};
			IDX_WD_COUNT: rd_byte = wdcnt_reg;
			IDX_WD_STAT: rd_byte = {3'h0, wdstat_reg, 4'h0};
			IDX_IRQ_STAT: rd_byte = {5'h00, irq_stat_reg};
			IDX_IRQ_MASK: rd_byte = {5'h00, irq_mask_reg};
			default: rd_byte = 8'h00;
		endcase
		if (!mapped) begin
			rd_byte = 8'h00;
		end
	end

	// ==========================================================
	// bus answer: ack one cycle after request, dropped the cycle after
	always_comb begin
		ack_next = acc & ~ack_reg;
		rdat_next = rdat_reg;
		if (acc && !ack_reg) begin
			rdat_next = rd_byte; // snapshot, held while ack is high
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdat_reg <= 8'h00;
		end else if (ce_i) begin
			ack_reg <= ack_next;
			rdat_reg <= rdat_next;
		end
	end

	// ==========================================================
	// configuration registers
	always_comb begin
		act_next = act_reg;
		base_hi_next = base_hi_reg;
		base_lo_next = base_lo_reg;
		mode_next = mode_reg;
		irq_mask_next = irq_mask_reg;
		if (wr_hit && mapped) begin
			case (idx)
				IDX_ACTIVATE: act_next = wdat & ACT_MASK;
				IDX_BASE_HI: base_hi_next = wdat & BASE_HI_MASK;
				IDX_BASE_LO: base_lo_next = wdat & BASE_LO_MASK;
				IDX_WD_MODE: begin
					// bit 0 and bits 7..5 are not stored
					mode_next = gpwd_wdmode_t'(wdat[4:1]);
				end
				IDX_IRQ_MASK: irq_mask_next = wdat[2:0] & IRQ_MASK_BITS;
				default: act_next = act_reg;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			act_reg <= RST_ACTIVATE;
			base_hi_reg <= RST_BASE;
			base_lo_reg <= RST_BASE;
			mode_reg <= gpwd_wdmode_t'(4'h0);
			irq_mask_reg <= 3'h0;
		end else if (ce_i) begin
			act_reg <= act_next;
			base_hi_reg <= base_hi_next;
			base_lo_reg <= base_lo_next;
			mode_reg <= mode_next;
			irq_mask_reg <= irq_mask_next;
		end
	end

	// ==========================================================
	// gpio ports: sync, edges, direction, data, inversion, status
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			sync1_next[p] = pin_v[p];
			sync2_next[p] = sync1_reg[p]; // first stage read here only
			prev_next[p] = sync2_reg[p];
			edge_v[p] = sync2_reg[p] ^ prev_reg[p]; // rising or falling
			dir_next[p] = dir_reg[p];
			val_next[p] = val_reg[p];
			inv_next[p] = inv_reg[p];
			stat_next[p] = stat_reg[p];
			if (wr_hit && mapped && idx == (p == 0 ? IDX_A_DIR : IDX_B_DIR)) begin
				dir_next[p] = wdat;
			end
			if (wr_hit && mapped && idx == (p == 0 ? IDX_A_VAL : IDX_B_VAL)) begin
				// input bits keep their old content
				val_next[p] = (val_reg[p] & dir_reg[p]) | (wdat & ~dir_reg[p]);
			end
			if (wr_hit && mapped && idx == (p == 0 ? IDX_A_INV : IDX_B_INV)) begin
				inv_next[p] = wdat;
			end
			// clear only what the read returned, so a fresh edge is not lost
			if (rd_hit && mapped && idx == (p == 0 ? IDX_A_STAT : IDX_B_STAT)) begin
				stat_next[p] = stat_reg[p] & ~rdat_reg;
			end
			stat_next[p] = stat_next[p] | edge_v[p]; // set wins
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int p = 0; p < 2; p++) begin
				sync1_reg[p] <= pin_v[p]; // start at the pin level, no false edge
				sync2_reg[p] <= pin_v[p];
				prev_reg[p] <= pin_v[p];
				dir_reg[p] <= RST_DIR;
				inv_reg[p] <= RST_INV;
				stat_reg[p] <= RST_ZERO;
			end
			val_reg[0] <= RST_A_VAL;
			val_reg[1] <= RST_B_VAL;
		end else if (ce_i) begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			prev_reg <= prev_next;
			dir_reg <= dir_next;
			val_reg <= val_next;
			inv_reg <= inv_next;
			stat_reg <= stat_next;
		end
	end

	// ==========================================================
	// watchdog time base
	assign ms_tick = (ms_reg == MS_LAST);
	assign sec_tick = ms_tick & (sub_reg == SUB_LAST);
	assign base_tick = mode_reg.fast ? ms_tick : sec_tick;
	assign unit_tick = mode_reg.minute ? (base_tick & (min_reg == MIN_LAST)) : base_tick;
	assign kbc_rise = kbc2_reg & ~kbc3_reg;
	assign cnt_load = wr_hit & mapped & (idx == IDX_WD_COUNT); // count register write
	// expiry, or the controller reset edge; a reload in the expiry cycle still rescues
	assign timeout_evt = (unit_tick & (wdcnt_reg == 8'h01) & ~cnt_load)
		| (mode_reg.kbc_trig & kbc_rise);

	// prescalers restart on every load so the first unit is whole
	always_comb begin
		ms_next = ms_tick ? '0 : MSW'(ms_reg + 1'b1);
		sub_next = sub_reg;
		min_next = min_reg;
		if (ms_tick) begin
			sub_next = (sub_reg == SUB_LAST) ? 10'h000 : 10'(sub_reg + 1'b1);
		end
		if (base_tick) begin
			min_next = (min_reg == MIN_LAST) ? 6'h00 : 6'(min_reg + 1'b1);
		end
		if (cnt_load) begin
			ms_next = '0;
			sub_next = 10'h000;
			min_next = 6'h00;
		end
	end

	// counter, status flag, keyboard reset pulse
	always_comb begin
		kbc1_next = kbd_ctrl_reset_line_i;
		kbc2_next = kbc1_reg;
		kbc3_next = kbc2_reg;
		wdcnt_next = wdcnt_reg;
		if (cnt_load) begin
			wdcnt_next = wdat; // zero leaves it stopped
		end else if (unit_tick && wdcnt_reg != 8'h00) begin
			wdcnt_next = 8'(wdcnt_reg - 1'b1);
		end
		wdstat_next = wdstat_reg;
		if (wr_hit && mapped && idx == IDX_WD_STAT && !wdat[WDSTAT_BIT]) begin
			wdstat_next = 1'b0;
		end
		wdstat_next = wdstat_next | timeout_evt; // set wins
		kb_next = (kb_reg != 8'h00) ? 8'(kb_reg - 1'b1) : 8'h00;
		if (timeout_evt && mode_reg.keyboard_reset_pin_en) begin
			kb_next = KB_LOAD;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ms_reg <= '0;
			sub_reg <= 10'h000;
			min_reg <= 6'h00;
			kbc1_reg <= 1'b0;
			kbc2_reg <= 1'b0;
			kbc3_reg <= 1'b0;
			wdcnt_reg <= RST_ZERO;
			wdstat_reg <= 1'b0;
			kb_reg <= 8'h00;
		end else if (ce_i) begin
			ms_reg <= ms_next;
			sub_reg <= sub_next;
			min_reg <= min_next;
			kbc1_reg <= kbc1_next;
			kbc2_reg <= kbc2_next;
			kbc3_reg <= kbc3_next;
			wdcnt_reg <= wdcnt_next;
			wdstat_reg <= wdstat_next;
			kb_reg <= kb_next;
		end
	end

	// ==========================================================
	// interrupt status: write one to clear, a new event wins
	always_comb begin
		irq_stat_next = irq_stat_reg;
		if (wr_hit && mapped && idx == IDX_IRQ_STAT) begin
			irq_stat_next = irq_stat_reg & ~wdat[2:0];
		end
		irq_stat_next[IRQ_A_BIT] = irq_stat_next[IRQ_A_BIT] | (|edge_v[0]);
		irq_stat_next[IRQ_B_BIT] = irq_stat_next[IRQ_B_BIT] | (|edge_v[1]);
		irq_stat_next[IRQ_WD_BIT] = irq_stat_next[IRQ_WD_BIT] | timeout_evt;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_reg <= 3'h0;
		end else if (ce_i) begin
			irq_stat_reg <= irq_stat_next;
		end
	end

	// ==========================================================
	// outputs
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = {24'h000000, rdat_reg};
	// inactive ports float every pin
	assign port_a_pins_o = val_reg[0] ^ inv_reg[0];
	assign port_b_pins_o = val_reg[1] ^ inv_reg[1];
	assign port_a_pins_oe_o = act_reg[ACT_A_BIT] ? ~dir_reg[0] : 8'h00;
	assign port_b_pins_oe_o = act_reg[ACT_B_BIT] ? ~dir_reg[1] : 8'h00;
	assign watchdog_timeout_out_n_o = ~(act_reg[ACT_WD_BIT] & wdstat_reg);
	assign power_led_o = act_reg[ACT_WD_BIT];
	assign keyboard_reset_pin_n_o = (kb_reg == 8'h00);
	assign io_base_o = {base_hi_reg[3:0], base_lo_reg};
	assign io_base_valid_o = (io_base_o >= BASE_MIN) && (io_base_o <= BASE_MAX);
	assign irq_o = |(irq_stat_reg & irq_mask_reg);

endmodule

/* File: verif/gpwd_properties.sv */
// port-level assertions for the gpio and watchdog configuration block
`timescale 1ns/10ps
module gpwd_properties
	import gpwd_pkg::*;
(
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// bus
	input wire gpwd_wb_req_t wb_req_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// pins
	input wire logic [7:0] port_a_pins_o,
	input wire logic [7:0] port_a_pins_oe_o,
	input wire logic [7:0] port_b_pins_o,
	input wire logic [7:0] port_b_pins_oe_o,
	// watchdog, led, base
	input wire logic watchdog_timeout_out_n_o,
	input wire logic keyboard_reset_pin_n_o,
	input wire logic power_led_o,
	input wire logic [11:0] io_base_o,
	input wire logic io_base_valid_o
);
	// ==========================================================
	// low-time counter of the keyboard reset pulse
	logic [7:0] low_reg; // cycles seen low so far
	logic [7:0] low_next;
	always_comb begin
		low_next = keyboard_reset_pin_n_o ? 8'h00 : low_reg + 8'h01;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			low_reg <= 8'h00;
		end else if (ce_i) begin
			low_reg <= low_next; // frozen together with the design
		end
	end
	// ==========================================================
	// properties
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_ACK_LATENCY: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o && ce_i |=> wb_ack_o)
		else $error("ack not one cycle after request");
	AST_ACK_SINGLE: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_DAT_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	AST_RESET_PINS: assert property ($past(rst_i) |-> port_b_pins_o == 8'h1F && port_a_pins_o == 8'h00
		&& port_a_pins_oe_o == 8'h00 && port_b_pins_oe_o == 8'h00)
		else $error("pin outputs wrong after reset");
	AST_LED_GATE: assert property (!watchdog_timeout_out_n_o |-> power_led_o)
		else $error("time-out output active while function off");
	AST_BASE_RANGE: assert property (io_base_o[1:0] == 2'h0 && io_base_valid_o
		== (io_base_o >= 12'h100 && io_base_o <= 12'hFF8))
		else $error("io base valid or alignment wrong");
	AST_PINS_BY_WRITE: assert property ($changed(port_a_pins_o) || $changed(port_a_pins_oe_o)
		|| $changed(port_b_pins_o) || $changed(port_b_pins_oe_o)
		|-> $past(wb_ack_o) || $past(wb_ack_o, 2))
		else $error("pin drive changed without a bus access");
	AST_KEYBOARD_RESET_PIN_WIDTH: assert property ($rose(keyboard_reset_pin_n_o) |-> low_reg == KEYBOARD_RESET_PIN_PULSE_CYCLES)
		else $error("keyboard reset pulse width wrong");
endmodule

/* File: verif/gpwd_pin_model.sv */
// board-side model of one 8-bit port
`timescale 1ns/10ps
module gpwd_pin_model (
	// device side
	input wire logic [7:0] drive_i,
	input wire logic [7:0] oe_i,
	// board side level
	input wire logic [7:0] board_i,
	// resolved pin level
	output logic [7:0] level_o
);
	// board holds every pin the device releases, so no pin floats
	assign level_o = (oe_i & drive_i) | (~oe_i & board_i);
endmodule

/* File: verif/gpwd_top_test.sv */
// self-checking bench for the gpio and watchdog configuration block
`timescale 1ns/10ps
module gpwd_top_test
	import gpwd_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	gpwd_wb_req_t req = '0;
	logic keyboard_controller = 1'b0; // controller reset line
	logic [7:0] board_a = 8'h00;
	logic [7:0] board_b = 8'h00;
	logic [31:0] rdat;
	logic ack, watchdog_timeout_out_n, keyboard_reset_pin_n, led, base_v, irq;
	logic [7:0] pa_o, pa_oe, pb_o, pb_oe, pa_i, pb_i;
	logic [11:0] base;
	int fail_count = 0;
	int n_checks = 0;
	// reset table, data registers read board level 00 on input pins
	logic [7:0] ridx [12] = '{8'h30, 8'h60, 8'h61, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5,
		8'hE6, 8'hE7, 8'hF5};
	logic [7:0] rval [12] = '{8'h02, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00,
		8'h00, 8'h00, 8'h00};
	// count mode, count, quiet cycles, window to fire (tick shortened to 5 cycles)
	logic [7:0] wmode [3] = '{8'h10, 8'h18, 8'h00};
	logic [7:0] wcnt [3] = '{8'h03, 8'h01, 8'h01};
	int quiet [3] = '{10, 280, 4900};
	int fire [3] = '{15, 40, 150};
	always #10 clk_i = ~clk_i;
	gpwd_top #(.MS_TICK_CYCLES(5)) gpwd_top_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.wb_req_i(req), .wb_dat_o(rdat), .wb_ack_o(ack), .port_a_pins_i(pa_i),
		.port_a_pins_o(pa_o), .port_a_pins_oe_o(pa_oe), .port_b_pins_i(pb_i),
		.port_b_pins_o(pb_o), .port_b_pins_oe_o(pb_oe), .kbd_ctrl_reset_line_i(keyboard_controller),
		.watchdog_timeout_out_n_o(watchdog_timeout_out_n), .keyboard_reset_pin_n_o(keyboard_reset_pin_n),
		.power_led_o(led), .io_base_o(base), .io_base_valid_o(base_v), .irq_o(irq));
	gpwd_pin_model gpwd_pin_model_a_i (.drive_i(pa_o), .oe_i(pa_oe), .board_i(board_a),
		.level_o(pa_i));
	gpwd_pin_model gpwd_pin_model_b_i (.drive_i(pb_o), .oe_i(pb_oe), .board_i(board_b),
		.level_o(pb_i));
	// ==========================================================
	// helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one classic cycle, held until ack is sampled
	task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd,
		output logic [7:0] q);
		int n;
		n = 0;
		req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {22'h0, idx, 2'h0}, sel: 4'hF,
			dat: {24'h0, wd}};
		@(posedge clk_i);
		while (ack !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 50) begin
			fail_count++;
			$display("[ERR] %0t no ack", $time);
		end
		q = rdat[7:0];
		req <= '0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, idx, d, q);
	endtask
	task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] q;
		wb(1'b0, idx, 8'h00, q);
		chk({24'h0, q}, {24'h0, exp});
	endtask
	// wait for time-out (pick 1) or keyboard reset (pick 0) going low
	task automatic wait_lo(input logic pick, input int lim, input logic want);
		int n;
		n = 0;
		while ((pick ? watchdog_timeout_out_n : keyboard_reset_pin_n) !== 1'b0 && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		chk(n < lim, want);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ==========================================================
	// watchdog against a hang, about three times the expected run
	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		complete_run();
	end
	// ==========================================================
	// tests
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int i = 0; i < 12; i++) rc(ridx[i], rval[i]);
		rc(8'h10, 8'h00);
		chk({pb_o, pa_o}, 16'h1F00);
		$display("reset values done");
		wr(IDX_ACTIVATE, 8'hFF);
		rc(IDX_ACTIVATE, 8'h07);
		chk(led, 1'b1);
		wr(IDX_WD_MODE, 8'hFF);
		rc(IDX_WD_MODE, 8'h1E);
		wr(IDX_BASE_HI, 8'hFF);
		wr(IDX_BASE_LO, 8'hFF);
		repeat (2) @(posedge clk_i);
		chk({base_v, base}, 13'h0FFC);
		wr(IDX_BASE_HI, 8'h01);
		wr(IDX_BASE_LO, 8'h00);
		repeat (2) @(posedge clk_i);
		chk({base_v, base}, 13'h1100);
		$display("activation and base done");
		board_a <= 8'h30;
		wr(IDX_A_DIR, 8'hF0);
		wr(IDX_A_VAL, 8'hA5);
		repeat (2) @(posedge clk_i);
		chk({pa_oe, pa_o}, 16'h0F05);
		rc(IDX_A_VAL, 8'h35);
		wr(IDX_A_INV, 8'hFF);
		repeat (2) @(posedge clk_i);
		chk(pa_o, 8'hFA);
		rc(IDX_A_VAL, 8'hC5);
		wr(IDX_ACTIVATE, 8'h04);
		repeat (2) @(posedge clk_i);
		chk({led, pa_oe}, 9'h000);
		wr(IDX_ACTIVATE, 8'h07);
		$display("port a drive done");
		rc(IDX_B_STAT, 8'h00);
		wr(IDX_IRQ_STAT, 8'h07);
		wr(IDX_IRQ_MASK, 8'h03);
		board_b <= 8'h81;
		repeat (6) @(posedge clk_i);
		chk(irq, 1'b1);
		rc(IDX_B_STAT, 8'h81);
		rc(IDX_B_STAT, 8'h00);
		rc(IDX_IRQ_STAT, 8'h02);
		wr(IDX_IRQ_STAT, 8'h02);
		repeat (2) @(posedge clk_i);
		chk(irq, 1'b0);
		wr(IDX_IRQ_MASK, 8'h00);
		board_b <= 8'h80;
		repeat (6) @(posedge clk_i);
		chk(irq, 1'b0);
		rc(IDX_IRQ_STAT, 8'h02);
		rc(IDX_B_STAT, 8'h01);
		wr(IDX_B_VAL, 8'h00);
		chk(pb_o, 8'h1F);
		wr(IDX_B_DIR, 8'hFE);
		wr(IDX_B_VAL, 8'h00);
		chk({pb_oe, pb_o}, 16'h011E);
		wr(IDX_B_DIR, 8'hFF);
		$display("edge status and interrupt done");
		wr(IDX_WD_MODE, 8'h06);
		keyboard_controller <= 1'b1;
		wait_lo(1'b0, 20, 1'b1);
		chk(watchdog_timeout_out_n, 1'b0);
		rc(IDX_WD_STAT, 8'h10);
		repeat (60) @(posedge clk_i);
		chk(keyboard_reset_pin_n, 1'b1);
		wr(IDX_WD_STAT, 8'h00);
		keyboard_controller <= 1'b0;
		wr(IDX_WD_MODE, 8'h04);
		chk(watchdog_timeout_out_n, 1'b1);
		keyboard_controller <= 1'b1;
		wait_lo(1'b1, 20, 1'b1);
		wait_lo(1'b0, 60, 1'b0);
		wr(IDX_WD_STAT, 8'h00);
		keyboard_controller <= 1'b0;
		wr(IDX_WD_MODE, 8'h00);
		keyboard_controller <= 1'b1;
		wait_lo(1'b1, 20, 1'b0);
		$display("keyboard trigger done");
		for (int i = 0; i < 3; i++) begin
			wr(IDX_WD_MODE, wmode[i]);
			wr(IDX_WD_STAT, 8'h00);
			wr(IDX_WD_COUNT, wcnt[i]);
			repeat (quiet[i]) @(posedge clk_i);
			chk(watchdog_timeout_out_n, 1'b1);
			wait_lo(1'b1, fire[i], 1'b1);
		end
		wr(IDX_WD_MODE, 8'h10);
		wr(IDX_WD_STAT, 8'h00);
		wr(IDX_WD_COUNT, 8'h03);
		rc(IDX_WD_COUNT, 8'h03);
		wr(IDX_WD_COUNT, 8'h00);
		rc(IDX_WD_COUNT, 8'h00);
		wait_lo(1'b1, 60, 1'b0);
		$display("count modes done");
		complete_run();
	end
endmodule
bind gpwd_top gpwd_properties gpwd_properties_i (.clk_i, .rst_i, .ce_i, .wb_req_i, .wb_dat_o,
	.wb_ack_o, .port_a_pins_o, .port_a_pins_oe_o, .port_b_pins_o, .port_b_pins_oe_o,
	.watchdog_timeout_out_n_o, .keyboard_reset_pin_n_o, .power_led_o, .io_base_o,
	.io_base_valid_o);
